/* File: src/icst_defs.svh */
/*
  Offsets, field positions, codes and timing constants of the idle
  command and standby timer block. Assumes inclusion by bare name.
*/
`ifndef ICST_DEFS_SVH
`define ICST_DEFS_SVH

// ******************************
// register byte offsets
// ******************************
`define ICST_OFS_PERIOD   8'h00
`define ICST_OFS_DRVHEAD  8'h04
`define ICST_OFS_CMD      8'h08
`define ICST_OFS_ERR      8'h0c
`define ICST_OFS_STAT     8'h10
`define ICST_OFS_CTRL     8'h14
`define ICST_OFS_IRQ_ST   8'h18
`define ICST_OFS_IRQ_MSK  8'h1c
`define ICST_OFS_PWR      8'h20

// ******************************
// field positions
// ******************************
`define ICST_ST_BUSY      7
`define ICST_ST_READY     6
`define ICST_ST_FAULT     5
`define ICST_ST_DATA_REQ  3
`define ICST_ST_ERR       0
`define ICST_ER_ABORT     2
`define ICST_DH_SEL       4
`define ICST_CT_PM_SUP    0
`define ICST_CT_FORCE_AB  1
`define ICST_IRQ_DONE     0
`define ICST_IRQ_ABORT    1
`define ICST_IRQ_STANDBY  2

// ******************************
// command and period codes
// ******************************
`define ICST_CMD_IDLE     8'he3
`define ICST_CMD_IDLE_NOW 8'he1
`define ICST_PER_OFF      8'h00
`define ICST_PER_LIN_MAX  8'hf0
`define ICST_PER_HH_MAX   8'hfb
`define ICST_PER_21M      8'hfc
`define ICST_PER_LONG     8'hfd
`define ICST_PER_RSVD     8'hfe
`define ICST_PER_21M15    8'hff

// ******************************
// timing, in seconds unless named
// ******************************
`define ICST_STEP_S       16'd5
`define ICST_HALFHR_S     16'd1800
`define ICST_21M_S        16'd1260
`define ICST_LONG_S       16'd36000
`define ICST_21M15_S      16'd1275
`define ICST_SEC_NS       1000000000
`define ICST_CLK_NS       10
`define ICST_CTRL_RST     8'h01

`endif

/* File: src/icst_pkg.sv */
/*
  Types of the idle command and standby timer block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package icst_pkg;

  // power mode of the device
  typedef enum logic [1:0] {
    ICST_PWR_ACTIVE,
    ICST_PWR_IDLE,
    ICST_PWR_STANDBY
  } icst_pwr_t;

  // command sequencer
  typedef enum logic [1:0] {
    ICST_CS_WAIT,
    ICST_CS_EXEC
  } icst_cmd_st_t;

endpackage : icst_pkg

/* File: src/icst_top.sv */
/*
  Idle command interpreter with automatic standby timer, an APB
  slave holding the task-file style registers, and two interrupt outputs.
  Assumes a single 100 MHz clock, synchronous inputs and an APB
  master that holds each request until pready.
*/
// Operation
// [RULE_01] idle command enters idle and reloads standby timer from period
// [RULE_02] nonzero period code picks timer period via fixed encoding
// [RULE_03] nonzero period code enables the standby timer
// [RULE_04] zero period code disables the standby timer
// [RULE_05] codes 01-f0 are code*5 s, f1-fb are (code-240)*30 min
// [RULE_06] fc 21 min, fd 8 to 12 h, ff 21 min 15 s, fe reserved
// [RULE_07] idle-now enters idle at once, timer untouched
// [RULE_08] completion interrupt may precede full idle entry
// [RULE_09] good completion clears busy, fault, data request, err; sets ready
// [RULE_10] abort either command without power management support
// [RULE_11] such abort sets abort bit 2 of error register
// [RULE_12] abort bit may be set when action cannot complete
// [RULE_13] error end clears busy, data request; keeps ready; err and fault as due
// [RULE_14] host selects drive by bit 4; device reports same selection
// [RULE_15] host issues idle commands only while ready reads one
// [RULE_16] enabled timer counts down in idle, expiry enters standby
`timescale 1ns/1ps
`include "icst_defs.svh"

module icst_top
  import icst_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int TICK_CYCLES = `ICST_SEC_NS / `ICST_CLK_NS
) (
  // clock and reset
  input  wire logic              I_CORE_CLK,
  input  wire logic              I_RST,
  // apb slave
  input  wire logic              I_PSEL,
  input  wire logic              I_PENABLE,
  input  wire logic              I_PWRITE,
  input  wire logic [ADDR_W-1:0] I_PADDR,
  input  wire logic [31:0]       I_PWDATA,
  output logic      [31:0]       O_PRDATA,
  output logic                   O_PREADY,
  output logic                   O_PSLVERR,
  // device condition
  input  wire logic              I_DEVICE_FAULT,
  // device outputs
  output logic                   O_INTRQ,
  output logic                   O_IRQ,
  output logic                   O_DRIVE_SEL,
  output logic                   O_IDLE_MODE,
  output logic                   O_STANDBY_MODE,
  output logic                   O_TIMER_EN
);

  // ******************************
  // elaboration checks
  // ******************************
  if (ADDR_W < 6) begin : g_chk_addr
    $error("ADDR_W too small for the register map");
  end
  if (TICK_CYCLES < 1) begin : g_chk_tick
    $error("TICK_CYCLES must be at least one");
  end

  // ******************************
  // period decode
  // ******************************
  // maps a period code to seconds; reserved and zero give zero
  function automatic logic [15:0] period_s(input logic [7:0] code);
    logic [15:0] c;
    c = {8'h00, code};
    period_s = 16'h0000;
    if (code == `ICST_PER_OFF)
      period_s = 16'h0000;
    else if (code <= `ICST_PER_LIN_MAX)
      period_s = 16'(c * `ICST_STEP_S); // [RULE_05]
    else if (code <= `ICST_PER_HH_MAX)
      period_s = 16'((c - {8'h00, `ICST_PER_LIN_MAX}) * `ICST_HALFHR_S); // [RULE_05]
    else if (code == `ICST_PER_21M)
      period_s = `ICST_21M_S; // [RULE_06]
    else if (code == `ICST_PER_LONG)
      period_s = `ICST_LONG_S; // [RULE_06]
    else if (code == `ICST_PER_21M15)
      period_s = `ICST_21M15_S; // [RULE_06]
  endfunction : period_s

  // true when an address matches a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0]        ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction : hit

  // ******************************
  // declarations
  // ******************************
  logic [7:0]   period_reg;
  logic [7:0]   drvhead_reg;
  logic [7:0]   cmd_reg;
  logic [7:0]   err_reg;
  logic [7:0]   stat_reg;
  logic [7:0]   ctrl_reg;
  logic [2:0]   irq_st_reg;
  logic [2:0]   irq_msk_reg;
  logic [31:0]  prdata_reg;
  logic         slverr_reg;
  logic         intrq_reg;
  icst_cmd_st_t cmd_st_reg;
  icst_pwr_t    pwr_reg;
  logic         tmr_en_reg;
  logic [15:0]  tmr_load_reg;
  logic [15:0]  tmr_left_reg;
  logic [31:0]  tick_cnt_reg;

  logic         setup;
  logic         access;
  logic         wr_acc;
  logic         rd_acc;
  logic         mapped;
  logic [31:0]  rd_mux;
  logic         cmd_wr;
  logic         is_idle;
  logic         is_now;
  logic         pm_ok;
  logic         abort_now;
  logic         done_now;
  logic         sec_tick;
  logic         expire;
  logic [2:0]   irq_set;
  logic [2:0]   irq_clr;

  // ******************************
  // apb decode
  // ******************************
  // zero wait state: the access phase always completes at once
  assign setup  = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE;
  assign wr_acc = access & I_PWRITE;
  assign rd_acc = access & ~I_PWRITE;

  always_comb begin
    mapped = hit(I_PADDR, `ICST_OFS_PERIOD)  | hit(I_PADDR, `ICST_OFS_DRVHEAD) |
             hit(I_PADDR, `ICST_OFS_CMD)     | hit(I_PADDR, `ICST_OFS_ERR)     |
             hit(I_PADDR, `ICST_OFS_STAT)    | hit(I_PADDR, `ICST_OFS_CTRL)    |
             hit(I_PADDR, `ICST_OFS_IRQ_ST)  | hit(I_PADDR, `ICST_OFS_IRQ_MSK) |
             hit(I_PADDR, `ICST_OFS_PWR);
  end

  // read mux; the command register is write only and reads zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(I_PADDR, `ICST_OFS_PERIOD))
      rd_mux[7:0] = period_reg;
    else if (hit(I_PADDR, `ICST_OFS_DRVHEAD))
      rd_mux[7:0] = drvhead_reg;
    else if (hit(I_PADDR, `ICST_OFS_ERR))
      rd_mux[7:0] = err_reg;
    else if (hit(I_PADDR, `ICST_OFS_STAT))
      rd_mux[7:0] = stat_reg;
    else if (hit(I_PADDR, `ICST_OFS_CTRL))
      rd_mux[7:0] = ctrl_reg;
    else if (hit(I_PADDR, `ICST_OFS_IRQ_ST))
      rd_mux[2:0] = irq_st_reg;
    else if (hit(I_PADDR, `ICST_OFS_IRQ_MSK))
      rd_mux[2:0] = irq_msk_reg;
    else if (hit(I_PADDR, `ICST_OFS_PWR))
      rd_mux[19:0] = {tmr_left_reg, 1'b0, tmr_en_reg, pwr_reg};
  end

  // read data and error are captured in setup so they come from flops
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_reg <= 32'h0000_0000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= I_PWRITE ? 32'h0000_0000 : rd_mux;
      slverr_reg <= ~mapped;
    end
  end

  assign O_PRDATA  = prdata_reg;
  assign O_PREADY  = access;
  assign O_PSLVERR = access & slverr_reg;

  // ******************************
  // host written registers
  // ******************************
  // a write to a register while busy is still taken; only a new
  // command is refused until the current one completes
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      period_reg  <= 8'h00;
      drvhead_reg <= 8'h00;
      ctrl_reg    <= `ICST_CTRL_RST;
      irq_msk_reg <= 3'h0;
    end else if (wr_acc && !slverr_reg) begin
      if (hit(I_PADDR, `ICST_OFS_PERIOD))
        period_reg <= I_PWDATA[7:0];
      if (hit(I_PADDR, `ICST_OFS_DRVHEAD))
        drvhead_reg <= I_PWDATA[7:0]; // [RULE_14]
      if (hit(I_PADDR, `ICST_OFS_CTRL))
        ctrl_reg <= I_PWDATA[7:0];
      if (hit(I_PADDR, `ICST_OFS_IRQ_MSK))
        irq_msk_reg <= I_PWDATA[2:0];
    end
  end

  // the selected drive is reported straight from the written bit
  assign O_DRIVE_SEL = drvhead_reg[`ICST_DH_SEL]; // [RULE_14]

  // ******************************
  // command sequencer
  // ******************************
  // a command is refused while busy; the host is expected to wait
  // for ready before issuing one
  assign cmd_wr = wr_acc & hit(I_PADDR, `ICST_OFS_CMD) &
                  (cmd_st_reg == ICST_CS_WAIT); // [RULE_15]

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cmd_st_reg <= ICST_CS_WAIT;
      cmd_reg    <= 8'h00;
    end else begin
      unique case (cmd_st_reg)
        ICST_CS_WAIT: begin
          if (cmd_wr) begin
            cmd_reg    <= I_PWDATA[7:0];
            cmd_st_reg <= ICST_CS_EXEC;
          end
        end
        ICST_CS_EXEC: begin
          cmd_st_reg <= ICST_CS_WAIT;
        end
        // two state codes of the encoding are unused; fall back to wait
        default: begin
          cmd_st_reg <= ICST_CS_WAIT;
        end
      endcase
    end
  end

  assign is_idle = (cmd_reg == `ICST_CMD_IDLE);
  assign is_now  = (cmd_reg == `ICST_CMD_IDLE_NOW);
  assign pm_ok   = ctrl_reg[`ICST_CT_PM_SUP];

  // unknown codes and the reserved period code cannot be served
  always_comb begin
    abort_now = 1'b0;
    if (cmd_st_reg == ICST_CS_EXEC) begin
      if (!pm_ok)
        abort_now = 1'b1; // [RULE_10]
      else if (ctrl_reg[`ICST_CT_FORCE_AB])
        abort_now = 1'b1; // [RULE_12]
      else if (!(is_idle || is_now))
        abort_now = 1'b1; // [RULE_12]
      else if (is_idle && period_reg == `ICST_PER_RSVD)
        abort_now = 1'b1; // [RULE_12]
    end
  end

  assign done_now = (cmd_st_reg == ICST_CS_EXEC) & ~abort_now;

  // ******************************
  // error and status registers
  // ******************************
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      err_reg <= 8'h00;
    end else if (cmd_wr) begin
      err_reg <= 8'h00;
    end else if (abort_now) begin
      err_reg[`ICST_ER_ABORT] <= 1'b1; // [RULE_11]
    end
  end

  // busy shows for the one execute cycle; err is set directly at an abort
  // and cleared only by a good completion, not read from the error register
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      stat_reg <= 8'h00;
      stat_reg[`ICST_ST_READY] <= 1'b1;
    end else if (cmd_wr) begin
      stat_reg[`ICST_ST_BUSY] <= 1'b1;
    end else if (done_now) begin
      stat_reg <= 8'h00; // [RULE_09]
      stat_reg[`ICST_ST_READY] <= 1'b1; // [RULE_09]
    end else if (abort_now) begin
      stat_reg[`ICST_ST_BUSY]  <= 1'b0; // [RULE_13]
      stat_reg[`ICST_ST_DATA_REQ] <= 1'b0; // [RULE_13]
      stat_reg[`ICST_ST_READY] <= 1'b1; // [RULE_13]
      stat_reg[`ICST_ST_ERR]   <= 1'b1; // [RULE_13]
      stat_reg[`ICST_ST_FAULT] <= I_DEVICE_FAULT; // [RULE_13]
    end
  end

  // ******************************
  // power mode and standby timer
  // ******************************
  // mode changes at completion, with the interrupt; the host may see
  // the interrupt before mechanics have settled, which is allowed
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_reg <= ICST_PWR_ACTIVE;
    end else if (done_now) begin
      pwr_reg <= ICST_PWR_IDLE; // [RULE_01] [RULE_07] [RULE_08]
    end else if (expire) begin
      pwr_reg <= ICST_PWR_STANDBY; // [RULE_16]
    end
  end

  // only the idle command touches the timer; idle-now leaves it
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tmr_en_reg   <= 1'b0;
      tmr_load_reg <= 16'h0000;
    end else if (done_now && is_idle) begin
      tmr_en_reg   <= (period_reg != `ICST_PER_OFF); // [RULE_03] [RULE_04]
      tmr_load_reg <= period_s(period_reg); // [RULE_01] [RULE_02]
    end
  end

  // one second prescaler, runs only while the countdown is live
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (done_now || !tmr_en_reg || pwr_reg != ICST_PWR_IDLE) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (sec_tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end

  assign sec_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // expiry when the last second elapses; a disabled timer never fires
  assign expire = tmr_en_reg & (pwr_reg == ICST_PWR_IDLE) &
                  sec_tick & (tmr_left_reg <= 16'h0001) & ~done_now; // [RULE_04]

  // remaining seconds; reloaded so the next idle spell counts in full
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      tmr_left_reg <= 16'h0000;
    end else if (done_now && is_idle) begin
      tmr_left_reg <= period_s(period_reg); // [RULE_01]
    end else if (expire) begin
      tmr_left_reg <= tmr_load_reg;
    end else if (sec_tick && tmr_en_reg && pwr_reg == ICST_PWR_IDLE) begin
      tmr_left_reg <= tmr_left_reg - 16'h0001; // [RULE_16]
    end
  end

  assign O_IDLE_MODE    = (pwr_reg == ICST_PWR_IDLE);
  assign O_STANDBY_MODE = (pwr_reg == ICST_PWR_STANDBY);
  assign O_TIMER_EN     = tmr_en_reg;

  // ******************************
  // completion interrupt line
  // ******************************
  // raised at completion, dropped by a status read or a new command
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      intrq_reg <= 1'b0;
    end else if (cmd_st_reg == ICST_CS_EXEC) begin
      intrq_reg <= 1'b1; // [RULE_08]
    end else if (cmd_wr || (rd_acc && hit(I_PADDR, `ICST_OFS_STAT))) begin
      intrq_reg <= 1'b0;
    end
  end

  assign O_INTRQ = intrq_reg;

  // ******************************
  // sticky event status and mask
  // ******************************
  assign irq_set[`ICST_IRQ_DONE]    = done_now;
  assign irq_set[`ICST_IRQ_ABORT]   = abort_now;
  assign irq_set[`ICST_IRQ_STANDBY] = expire;

  // only bits seen by this read are cleared, and a new event wins
  assign irq_clr = (rd_acc && hit(I_PADDR, `ICST_OFS_IRQ_ST)) ?
                   prdata_reg[2:0] : 3'h0;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_st_reg <= 3'h0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
    end
  end

  assign O_IRQ = |(irq_st_reg & irq_msk_reg);

endmodule : icst_top

/* File: verification/icst_chk.sv */
/*
  Checker of the idle command block, bound to icst_top.
  Assumes it sees only top ports; tracks period and control writes itself.
*/
`timescale 1ns/1ps
`include "icst_defs.svh"

module icst_chk #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic              I_CORE_CLK,
  input wire logic              I_RST,
  // apb
  input wire logic              I_PSEL,
  input wire logic              I_PENABLE,
  input wire logic              I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0]       I_PWDATA,
  input wire logic              O_PREADY,
  input wire logic              O_PSLVERR,
  // device outputs
  input wire logic              O_INTRQ,
  input wire logic              O_DRIVE_SEL,
  input wire logic              O_IDLE_MODE,
  input wire logic              O_STANDBY_MODE,
  input wire logic              O_TIMER_EN
);
  logic [7:0] per_reg;
  logic [1:0] ctl_reg;
  logic       wr_acc;
  logic       cmd_acc;
  logic       cmd_ok;
  logic       e3_ok;

  // write access decode, mirrors the slave's taking edge
  assign wr_acc  = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
  assign cmd_acc = wr_acc && I_PADDR == ADDR_W'(`ICST_OFS_CMD);
  assign cmd_ok  = ctl_reg == 2'h1;
  assign e3_ok   = cmd_acc && cmd_ok && I_PWDATA[7:0] == `ICST_CMD_IDLE && per_reg != `ICST_PER_RSVD;

  // shadow of period and control, needed to predict aborts
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      per_reg <= 8'h00;
      ctl_reg <= 2'h1;
    end else if (wr_acc && I_PADDR == ADDR_W'(`ICST_OFS_PERIOD)) begin
      per_reg <= I_PWDATA[7:0];
    end else if (wr_acc && I_PADDR == ADDR_W'(`ICST_OFS_CTRL)) begin
      ctl_reg <= I_PWDATA[1:0];
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  // ******************************
  // assertions
  // ******************************
  a_zero_wait:
    assert property (I_PSEL && I_PENABLE |-> O_PREADY) else $error("pready missing in access");
  a_unmapped_err:
    assert property (I_PSEL && I_PENABLE && I_PADDR > ADDR_W'(`ICST_OFS_PWR) |-> O_PSLVERR)
      else $error("no error on unmapped address");
  a_drive_select:
    assert property (wr_acc && I_PADDR == ADDR_W'(`ICST_OFS_DRVHEAD) |=> O_DRIVE_SEL == $past(I_PWDATA[4]))
      else $error("drive select not reported");
  a_idle_entry:
    assert property ((e3_ok || cmd_acc && cmd_ok && I_PWDATA[7:0] == `ICST_CMD_IDLE_NOW)
                     |-> ##2 O_IDLE_MODE && O_INTRQ)
      else $error("idle not entered after command");
  a_timer_on:
    assert property (e3_ok && per_reg != 8'h00 |-> ##2 O_TIMER_EN) else $error("timer not enabled");
  a_timer_off:
    assert property (e3_ok && per_reg == 8'h00 |-> ##2 !O_TIMER_EN) else $error("timer not disabled");
  a_now_keeps:
    assert property (cmd_acc && I_PWDATA[7:0] == `ICST_CMD_IDLE_NOW |=> $stable(O_TIMER_EN) [*2])
      else $error("idle now changed timer");
  a_abort_holds:
    assert property (cmd_acc && !cmd_ok |=> ##1 $stable(O_IDLE_MODE) && $stable(O_TIMER_EN) && O_INTRQ)
      else $error("aborted command changed mode");
  a_standby_cause:
    assert property ($rose(O_STANDBY_MODE) |-> $past(O_IDLE_MODE) && O_TIMER_EN)
      else $error("standby without enabled timer");
  a_intrq_cause:
    assert property ($rose(O_INTRQ) |-> $past(cmd_acc, 2)) else $error("interrupt without command");
endmodule : icst_chk

/* File: verification/icst_host.sv */
/*
  Host model: APB master writing the task-file registers.
  Assumes a zero or more wait state slave; waits are cut by the bench.
*/
`timescale 1ns/1ps
`include "icst_defs.svh"

module icst_host (
  // clock
  input  wire logic        i_clk,
  // apb master side
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 8'h00;
    o_pwdata  = 32'h0;
  end

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
  endtask : xfer

  // command only goes out while the device reports ready
  task automatic issue_cmd(input logic [7:0] code);
    logic [31:0] q;
    logic        e;
    xfer(1'b0, `ICST_OFS_STAT, 32'h0, q, e);
    if (q[`ICST_ST_READY] === 1'b1) xfer(1'b1, `ICST_OFS_CMD, {24'h0, code}, q, e);
  endtask : issue_cmd
endmodule : icst_host

/* File: verification/idle_command_standby_timer_bench.sv */
/*
  Self-checking bench of icst_top with host model and bound checker.
  Assumes a short second (TICK cycles) so timer expiry fits the run.
*/
`timescale 1ns/1ps
`include "icst_defs.svh"

bind icst_top icst_chk #(.ADDR_W(ADDR_W)) chk_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_INTRQ(O_INTRQ), .O_DRIVE_SEL(O_DRIVE_SEL), .O_IDLE_MODE(O_IDLE_MODE),
  .O_STANDBY_MODE(O_STANDBY_MODE), .O_TIMER_EN(O_TIMER_EN));

module idle_command_standby_timer_bench;
  localparam int TICK = 64; // short second keeps expiry within a few hundred cycles
  logic        I_CORE_CLK = 1'b0;
  logic        I_RST = 1'b1;
  logic        I_DEVICE_FAULT = 1'b0;
  logic        I_PSEL, I_PENABLE, I_PWRITE, O_PREADY, O_PSLVERR, O_INTRQ, O_IRQ;
  logic        O_DRIVE_SEL, O_IDLE_MODE, O_STANDBY_MODE, O_TIMER_EN, re;
  logic [7:0]  I_PADDR;
  logic [31:0] I_PWDATA, O_PRDATA, rq;
  int          fail_count = 0;
  int          cmp_count = 0;

  always #5 I_CORE_CLK = ~I_CORE_CLK;

  icst_top #(.ADDR_W(8), .TICK_CYCLES(TICK)) dut_u (.I_CORE_CLK(I_CORE_CLK), .I_RST(I_RST), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_DEVICE_FAULT(I_DEVICE_FAULT), .O_INTRQ(O_INTRQ),
    .O_IRQ(O_IRQ), .O_DRIVE_SEL(O_DRIVE_SEL), .O_IDLE_MODE(O_IDLE_MODE), .O_STANDBY_MODE(O_STANDBY_MODE),
    .O_TIMER_EN(O_TIMER_EN));
  icst_host host_u (.i_clk(I_CORE_CLK), .o_psel(I_PSEL), .o_penable(I_PENABLE), .o_pwrite(I_PWRITE),
    .o_paddr(I_PADDR), .o_pwdata(I_PWDATA), .i_prdata(O_PRDATA), .i_pready(O_PREADY), .i_pslverr(O_PSLVERR));

  // ******************************
  // shared tasks
  // ******************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, rq, re);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host_u.xfer(1'b0, a, 32'h0, rq, re);
  endtask : rd
  // standby period in seconds, from the code table
  function automatic logic [15:0] secs(input logic [7:0] c);
    if (c <= 8'hf0) return 16'(c) * 16'd5;
    if (c <= 8'hfb) return (16'(c) - 16'd240) * 16'd1800;
    if (c == 8'hfc) return 16'd1260;
    if (c == 8'hfd) return 16'd36000; // chosen inside the 8 to 12 hour span
    return 16'd1275;
  endfunction : secs
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ******************************
  // scenarios
  // ******************************
  task automatic test_reset();
    logic [7:0]  ra [6] = '{8'h10, 8'h0c, 8'h14, 8'h20, 8'h00, 8'h1c};
    logic [31:0] rv [6] = '{32'h40, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk("reset value", rq, rv[i]);
    end
    wr(8'h40, 32'hff);
    chk("unmapped write error", 32'(re), 32'h1);
    rd(8'h40);
    chk("unmapped read", {rq[30:0], re}, 32'h1);
    $display("test reset done");
  endtask : test_reset

  task automatic test_codes();
    logic [7:0]  cd [7] = '{8'h01, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
    logic [15:0] s;
    for (int i = 0; i < 7; i++) begin
      wr(`ICST_OFS_PERIOD, {24'h0, cd[i]});
      wr(`ICST_OFS_DRVHEAD, {27'h0, cd[i][0], 4'h0});
      host_u.issue_cmd(`ICST_CMD_IDLE);
      rd(`ICST_OFS_PWR);
      s = secs(cd[i]); // the read lands well before the first second elapses
      chk("power word", rq, {12'h0, s, 4'h5});
      #1 chk("completion intrq", 32'(O_INTRQ), 32'h1);
      rd(`ICST_OFS_STAT);
      chk("good status", rq, 32'h40);
      #1 chk("drive select", 32'(O_DRIVE_SEL), 32'(cd[i][0]));
    end
    $display("test codes done");
  endtask : test_codes

  task automatic test_now_zero();
    wr(`ICST_OFS_PERIOD, 32'h2);
    host_u.issue_cmd(`ICST_CMD_IDLE);
    wr(`ICST_OFS_PERIOD, 32'h0);
    host_u.issue_cmd(`ICST_CMD_IDLE_NOW);
    rd(`ICST_OFS_PWR);
    chk("idle now keeps timer", {29'h0, rq[2:0]}, 32'h5);
    host_u.issue_cmd(`ICST_CMD_IDLE);
    rd(`ICST_OFS_PWR);
    chk("zero disables timer", {29'h0, rq[2:0]}, 32'h1);
    $display("test now and zero done");
  endtask : test_now_zero

  task automatic test_abort();
    logic [1:0] ct [5] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h1};
    logic [7:0] cd [5] = '{8'he3, 8'he1, 8'he3, 8'he3, 8'h55};
    for (int i = 0; i < 5; i++) begin
      I_DEVICE_FAULT <= i[0];
      wr(`ICST_OFS_CTRL, {30'h0, ct[i]});
      wr(`ICST_OFS_PERIOD, (i == 3) ? 32'hfe : 32'h1);
      host_u.issue_cmd(cd[i]);
      rd(`ICST_OFS_ERR);
      chk("abort error", rq, 32'h4);
      rd(`ICST_OFS_STAT);
      chk("abort status", rq, {26'h0, i[0], 5'h1} | 32'h40);
      #1 chk("timer held", 32'(O_TIMER_EN), 32'h0);
    end
    wr(`ICST_OFS_CTRL, 32'h1);
    host_u.issue_cmd(`ICST_CMD_IDLE_NOW);
    rd(`ICST_OFS_STAT);
    chk("fault cleared", rq, 32'h40);
    I_DEVICE_FAULT <= 1'b0;
    $display("test abort done");
  endtask : test_abort

  task automatic test_irq();
    wr(`ICST_OFS_IRQ_MSK, 32'h3);
    rd(`ICST_OFS_IRQ_ST);
    host_u.issue_cmd(`ICST_CMD_IDLE_NOW);
    @(posedge I_CORE_CLK); // completion lands one edge after the command write
    #1 chk("irq unmasked", 32'(O_IRQ), 32'h1);
    rd(`ICST_OFS_IRQ_ST);
    chk("irq status", rq, 32'h1);
    #1 chk("irq after clear", 32'(O_IRQ), 32'h0);
    wr(`ICST_OFS_IRQ_MSK, 32'h0);
    host_u.issue_cmd(`ICST_CMD_IDLE_NOW);
    @(posedge I_CORE_CLK);
    #1 chk("irq masked", 32'({O_IRQ, O_INTRQ}), 32'h1);
    rd(`ICST_OFS_STAT);
    #1 chk("intrq cleared", 32'(O_INTRQ), 32'h0);
    $display("test irq done");
  endtask : test_irq

  task automatic test_standby();
    int n;
    wr(`ICST_OFS_IRQ_MSK, 32'h4);
    rd(`ICST_OFS_IRQ_ST);
    wr(`ICST_OFS_PERIOD, 32'h1);
    host_u.issue_cmd(`ICST_CMD_IDLE);
    for (n = 0; n < 6 * TICK && O_STANDBY_MODE !== 1'b1; n++) @(posedge I_CORE_CLK);
    #1 chk("standby delay", 32'(n >= 4 * TICK && n <= 5 * TICK + 8), 32'h1);
    chk("standby modes", 32'({O_STANDBY_MODE, O_IDLE_MODE, O_IRQ}), 32'h5);
    rd(`ICST_OFS_IRQ_ST);
    // done bit of the idle command is still pending beside the standby bit
    chk("standby irq", rq, 32'h5);
    $display("test standby done");
  endtask : test_standby

  // watchdog at 50000 cycles, far beyond the under one thousand cycles the tests need
  initial begin
    #500000;
    fail_count++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    test_reset();
    test_codes();
    test_now_zero();
    test_abort();
    test_irq();
    test_standby();
    print_verdict();
  end
endmodule : idle_command_standby_timer_bench
